// ---- design/flash_map_front.sv ----
// flash address map, information overlay and program/erase access control
// ------------------------------------------------------------
// Summary of operation
// - main array is 8192 or 4096 bytes, programmable by core and debug port
// - array is split into 512-byte pages, the smallest erasable unit
// - eight sectors, each protectable against program and page erase
// - sectors 0..7 are ascending ranges of 1024 or 512 bytes
// - information area is enabled only while page select bit 7 is one
// - enabled information area overlays addresses FE00..FFFF
// - data loads in the overlay return information area bytes
// - instruction fetches always come from the main array
// - information area is read only, writes never change it
// - FE40..FE53 hold a 20-character zero-padded part identifier
// - controller drives array strobes and timing for program and erase
// - command register unlock scheme guards against stray program or erase
// - erased bytes read FF; programming only clears bits
// ------------------------------------------------------------
`timescale 1ns/1ps
module flash_map_front #(
  parameter int FLASH_BYTES  = flash_map_pkg::SIZE_LARGE,
  parameter int PROG_CYC     = flash_map_pkg::PROG_CYCLES,
  parameter int ERASE_CYC    = flash_map_pkg::ERASE_CYCLES,
  parameter int MASS_CYC     = flash_map_pkg::MASS_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        fetch_req,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        load_req,
  input  wire logic [15:0] load_addr,
  input  wire logic        store_req,
  input  wire logic [15:0] store_addr,
  input  wire logic [7:0]  store_data,
  input  wire logic        reg_wr,
  input  wire logic        reg_sel,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        dbg_prog_req,
  input  wire logic        dbg_erase_req,
  input  wire logic        dbg_mass_req,
  input  wire logic [15:0] dbg_addr,
  input  wire logic [7:0]  dbg_wdata,
  input  wire logic [7:0]  arr_rdata,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic             busy,
  output logic             unlocked,
  output logic      [7:0]  page_select,
  output logic      [7:0]  sector_protect,
  output logic      [15:0] arr_addr,
  output logic             arr_rd,
  output logic      [7:0]  arr_wdata,
  output logic             arr_prog,
  output logic             arr_erase,
  output logic             arr_mass
);
  import flash_map_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  lock_state_t       lk_reg, lk_next;
  logic [7:0]        page_reg, page_next;
  logic [7:0]        prot_reg, prot_next;
  logic              psel_reg, psel_next;
  op_state_t         op_reg, op_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [15:0]       aaddr_reg, aaddr_next;
  logic              ard_reg, ard_next;
  logic [7:0]        awd_reg, awd_next;
  logic              aprog_reg, aprog_next;
  logic              aerase_reg, aerase_next;
  logic              amass_reg, amass_next;
  logic              info_reg, info_next;
  logic [7:0]        rdd_reg, rdd_next;
  logic              rdv_reg, rdv_next;
  logic              busy_reg, busy_next;
  logic              unl_reg, unl_next;
  logic [2:0]        st_sector, pg_sector, dbg_sector;
  logic [6:0]        st_page, dbg_page;
  logic              st_in, dbg_in;
  logic [7:0]        info_q;
  logic              idle;
  logic              info_en;
  logic              erase_go;
  logic              store_ok;
  logic              load_info;
  logic [15:0]       rd_addr;

  // ----------------------------------------
  // decoders and information area
  // ----------------------------------------
  flash_sector_decode #(.FLASH_BYTES(FLASH_BYTES)) u_dec_store (
    .addr     (store_addr),
    .sector   (st_sector),
    .page     (st_page),
    .in_array (st_in)
  );

  flash_sector_decode #(.FLASH_BYTES(FLASH_BYTES)) u_dec_page (
    .addr     ({page_reg[PAGE_W-1:0], 9'h000}),
    .sector   (pg_sector),
    .page     (),
    .in_array ()
  );

  flash_sector_decode #(.FLASH_BYTES(FLASH_BYTES)) u_dec_dbg (
    .addr     (dbg_addr),
    .sector   (dbg_sector),
    .page     (dbg_page),
    .in_array (dbg_in)
  );

  info_area_rom u_info (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .addr    (rd_addr[INFO_AW-1:0]),
    .rdata   (info_q)
  );

  // ----------------------------------------
  // shared terms
  // ----------------------------------------
  always_comb begin
    idle      = (op_reg == OP_IDLE);
    info_en   = page_reg[INFO_EN_BIT];
    load_info = info_en && (load_addr[ADDR_W-1:PAGE_SHIFT] == INFO_PAGE);
    rd_addr   = fetch_req ? fetch_addr : load_addr;
    erase_go  = idle && reg_wr && reg_sel == SEL_COMMAND && !psel_reg
                && reg_wdata == CMD_PAGE_ERASE && lk_reg == LK_UNLOCKED
                && !prot_reg[pg_sector]
                && ({page_reg[PAGE_W-1:0], 9'h000} < 16'(FLASH_BYTES));
    store_ok  = lk_reg == LK_UNLOCKED && st_in
                && st_page == page_reg[PAGE_W-1:0]
                && !prot_reg[st_sector]
                && !(info_en && st_page == INFO_PAGE);
  end

  // ----------------------------------------
  // unlock sequence and protection
  // ----------------------------------------
  always_comb begin
    lk_next   = lk_reg;
    page_next = page_reg;
    prot_next = prot_reg;
    psel_next = psel_reg;
    if (idle && reg_wr) begin
      if (reg_sel == SEL_COMMAND) begin
        psel_next = (reg_wdata == CMD_PROT_SEL);
        case (reg_wdata)
          CMD_CLEAR:      lk_next = LK_CLEARED;
          CMD_KEY_FIRST:  lk_next = (lk_reg == LK_PAGE) ? LK_KEY1 : LK_LOCKED;
          CMD_KEY_SECOND: lk_next = (lk_reg == LK_KEY1) ? LK_KEY2 : LK_LOCKED;
          default:        lk_next = LK_LOCKED;
        endcase
      end else if (psel_reg) begin
        prot_next = prot_reg | reg_wdata;
      end else begin
        page_next = reg_wdata;
        if (lk_reg == LK_CLEARED) begin
          lk_next = LK_PAGE;
        end else if (lk_reg == LK_KEY2 && reg_wdata == page_reg) begin
          lk_next = LK_UNLOCKED;
        end else begin
          lk_next = LK_LOCKED;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lk_reg   <= LK_LOCKED;
      page_reg <= 8'h00;
      prot_reg <= 8'h00;
      psel_reg <= 1'b0;
    end else if (clk_en) begin
      lk_reg   <= lk_next;
      page_reg <= page_next;
      prot_reg <= prot_next;
      psel_reg <= psel_next;
    end
  end

  // ----------------------------------------
  // array access and operation timing
  // ----------------------------------------
  always_comb begin
    op_next     = op_reg;
    cnt_next    = cnt_reg;
    aaddr_next  = aaddr_reg;
    ard_next    = 1'b0;
    awd_next    = awd_reg;
    aprog_next  = aprog_reg;
    aerase_next = aerase_reg;
    amass_next  = amass_reg;
    info_next   = info_reg;
    rdd_next    = rdd_reg;
    rdv_next    = 1'b0;
    case (op_reg)
      OP_IDLE: begin
        if (dbg_mass_req) begin
          amass_next = 1'b1;
          cnt_next   = CNT_W'(MASS_CYC - 1);
          op_next    = OP_MASS;
        end else if (dbg_erase_req && dbg_in && !prot_reg[dbg_sector]) begin
          aaddr_next  = {dbg_page, 9'h000};
          aerase_next = 1'b1;
          cnt_next    = CNT_W'(ERASE_CYC - 1);
          op_next     = OP_ERASE;
        end else if (dbg_prog_req && dbg_in && !prot_reg[dbg_sector]) begin
          aaddr_next = dbg_addr;
          awd_next   = dbg_wdata;
          ard_next   = 1'b1;
          op_next    = OP_PROG_RD;
        end else if (erase_go) begin
          aaddr_next  = {page_reg[PAGE_W-1:0], 9'h000};
          aerase_next = 1'b1;
          cnt_next    = CNT_W'(ERASE_CYC - 1);
          op_next     = OP_ERASE;
        end else if (store_req && store_ok) begin
          aaddr_next = store_addr;
          awd_next   = store_data;
          ard_next   = 1'b1;
          op_next    = OP_PROG_RD;
        end else if (fetch_req) begin
          aaddr_next = fetch_addr;
          ard_next   = 1'b1;
          info_next  = 1'b0;
          op_next    = OP_READ;
        end else if (load_req) begin
          aaddr_next = load_addr;
          ard_next   = !load_info;
          info_next  = load_info;
          op_next    = OP_READ;
        end
      end
      OP_READ: begin
        rdd_next = info_reg ? info_q : arr_rdata;
        rdv_next = 1'b1;
        op_next  = OP_IDLE;
      end
      OP_PROG_RD: begin
        awd_next   = awd_reg & arr_rdata;
        aprog_next = 1'b1;
        cnt_next   = CNT_W'(PROG_CYC - 1);
        op_next    = OP_PROG;
      end
      OP_PROG, OP_ERASE, OP_MASS: begin
        if (cnt_reg == '0) begin
          aprog_next  = 1'b0;
          aerase_next = 1'b0;
          amass_next  = 1'b0;
          op_next     = OP_IDLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        aprog_next  = 1'b0;
        aerase_next = 1'b0;
        amass_next  = 1'b0;
        op_next     = OP_IDLE;
      end
    endcase
    busy_next = (op_next == OP_PROG_RD) || (op_next == OP_PROG)
                || (op_next == OP_ERASE) || (op_next == OP_MASS);
    unl_next  = (lk_next == LK_UNLOCKED);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      op_reg     <= OP_IDLE;
      cnt_reg    <= '0;
      aaddr_reg  <= 16'h0000;
      ard_reg    <= 1'b0;
      awd_reg    <= ERASED_BYTE;
      aprog_reg  <= 1'b0;
      aerase_reg <= 1'b0;
      amass_reg  <= 1'b0;
      info_reg   <= 1'b0;
      rdd_reg    <= 8'h00;
      rdv_reg    <= 1'b0;
      busy_reg   <= 1'b0;
      unl_reg    <= 1'b0;
    end else if (clk_en) begin
      op_reg     <= op_next;
      cnt_reg    <= cnt_next;
      aaddr_reg  <= aaddr_next;
      ard_reg    <= ard_next;
      awd_reg    <= awd_next;
      aprog_reg  <= aprog_next;
      aerase_reg <= aerase_next;
      amass_reg  <= amass_next;
      info_reg   <= info_next;
      rdd_reg    <= rdd_next;
      rdv_reg    <= rdv_next;
      busy_reg   <= busy_next;
      unl_reg    <= unl_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rd_data        = rdd_reg;
  assign rd_valid       = rdv_reg;
  assign busy           = busy_reg;
  assign unlocked       = unl_reg;
  assign page_select    = page_reg;
  assign sector_protect = prot_reg;
  assign arr_addr       = aaddr_reg;
  assign arr_rd         = ard_reg;
  assign arr_wdata      = awd_reg;
  assign arr_prog       = aprog_reg;
  assign arr_erase      = aerase_reg;
  assign arr_mass       = amass_reg;
endmodule : flash_map_front

// ---- design/flash_map_pkg.sv ----
// shared constants and types for the flash address-map front end
package flash_map_pkg;
  // ----------------------------------------
  // array organisation
  // ----------------------------------------
  localparam int          ADDR_W         = 16;
  localparam int          PAGE_SHIFT     = 9;
  localparam int          PAGE_W         = 7;
  localparam int          SECTOR_W       = 3;
  localparam int          NUM_SECTORS    = 8;
  localparam int          SIZE_LARGE     = 8192;
  localparam int          SIZE_SMALL     = 4096;
  localparam int          INFO_DEPTH     = 512;
  localparam int          INFO_AW        = 9;
  localparam logic [6:0]  INFO_PAGE      = 7'h7F;
  localparam int          INFO_EN_BIT    = 7;
  localparam logic [8:0]  ID_FIRST       = 9'h040;
  localparam logic [8:0]  ID_LAST        = 9'h053;
  localparam int          ID_CHARS       = 20;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [7:0]  RSVD_BYTE      = 8'hFF;
  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0]  CMD_CLEAR      = 8'h00;
  localparam logic [7:0]  CMD_KEY_FIRST  = 8'h73;
  localparam logic [7:0]  CMD_KEY_SECOND = 8'h8C;
  localparam logic [7:0]  CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0]  CMD_PROT_SEL   = 8'h5E;
  localparam logic        SEL_COMMAND    = 1'b0;
  localparam logic        SEL_PAGE       = 1'b1;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CLK_MHZ        = 200;
  localparam int          PROG_TIME_NS   = 40000;
  localparam int          ERASE_TIME_NS  = 10000000;
  localparam int          MASS_TIME_NS   = 20000000;
  // products are formed at 64 bits, the mass erase product overflows 32
  localparam int          PROG_CYCLES    = int'((longint'(PROG_TIME_NS) * CLK_MHZ + 999) / 1000);
  localparam int          ERASE_CYCLES   = int'((longint'(ERASE_TIME_NS) * CLK_MHZ + 999) / 1000);
  localparam int          MASS_CYCLES    = int'((longint'(MASS_TIME_NS) * CLK_MHZ + 999) / 1000);
  localparam int          CNT_W          = 32;
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [2:0] {
    LK_LOCKED, LK_CLEARED, LK_PAGE, LK_KEY1, LK_KEY2, LK_UNLOCKED
  } lock_state_t;
  typedef enum logic [2:0] {
    OP_IDLE, OP_READ, OP_PROG_RD, OP_PROG, OP_ERASE, OP_MASS
  } op_state_t;
endpackage : flash_map_pkg

// ---- design/flash_sector_decode.sv ----
// address to sector, page and range decode
`timescale 1ns/1ps
module flash_sector_decode #(
  parameter int FLASH_BYTES = 8192
) (
  input  wire logic [15:0] addr,
  output logic      [2:0]  sector,
  output logic      [6:0]  page,
  output logic             in_array
);
  import flash_map_pkg::*;
  localparam int SEC_SHIFT = $clog2(FLASH_BYTES / NUM_SECTORS);

  always_comb begin
    sector   = addr[SEC_SHIFT +: SECTOR_W];
    page     = addr[ADDR_W-1:PAGE_SHIFT];
    in_array = ({16'h0000, addr} < 32'(FLASH_BYTES));
  end
endmodule : flash_sector_decode

// ---- design/info_area_rom.sv ----
// read-only information area, registered read
`timescale 1ns/1ps
module info_area_rom #(
  parameter logic [159:0] PART_ID = "FMAP0000TESTPART0001"  // arbitrary value
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic [8:0]  addr,
  output logic      [7:0]  rdata
);
  import flash_map_pkg::*;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [8:0] idx;

  always_comb begin
    idx        = addr - ID_FIRST;
    rdata_next = RSVD_BYTE;
    if (addr >= ID_FIRST && addr <= ID_LAST) begin
      rdata_next = PART_ID[8*(ID_CHARS-1-int'(idx)) +: 8];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
endmodule : info_area_rom

// ---- verif/flash_array_model.sv ----
// behavioural model of the flash array behind the front end
`timescale 1ns/1ps
module flash_array_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] arr_addr,
  input  wire logic        arr_rd,
  input  wire logic [7:0]  arr_wdata,
  input  wire logic        arr_prog,
  input  wire logic        arr_erase,
  input  wire logic        arr_mass,
  output logic      [7:0]  arr_rdata
);
  logic [7:0] mem [0:8191];
  logic [7:0] last_rd = 8'h00;
  logic       prog_q  = 1'b0;
  logic       erase_q = 1'b0;
  logic       mass_q  = 1'b0;
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
  end
  // released bus shows the inverse of the last byte
  assign arr_rdata = arr_rd ? mem[arr_addr[12:0]] : ~last_rd;
  always @(posedge clk_sys) begin
    if (arr_rd) last_rd <= mem[arr_addr[12:0]];
    if (arr_prog && !prog_q) mem[arr_addr[12:0]] <= mem[arr_addr[12:0]] & arr_wdata;
    if (arr_erase && !erase_q) begin
      for (int i = 0; i < 512; i++) mem[{arr_addr[12:9], 9'h000} + i] <= 8'hFF;
    end
    if (arr_mass && !mass_q) begin
      for (int i = 0; i < 8192; i++) mem[i] <= 8'hFF;
    end
    prog_q  <= arr_prog;
    erase_q <= arr_erase;
    mass_q  <= arr_mass;
  end
endmodule : flash_array_model

// ---- verif/flash_map_front_sva.sv ----
// assertion checker for the flash map front end
`timescale 1ns/1ps
module flash_map_front_sva #(
  parameter int FLASH_BYTES = 8192,
  parameter int PROG_CYC    = 4,
  parameter int ERASE_CYC   = 8,
  parameter int MASS_CYC    = 12
) (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        clk_en,
  input wire logic        dbg_prog_req,
  input wire logic        reg_wr,
  input wire logic        reg_sel,
  input wire logic [7:0]  arr_rdata,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic        busy,
  input wire logic        unlocked,
  input wire logic [7:0]  page_select,
  input wire logic [7:0]  sector_protect,
  input wire logic [15:0] arr_addr,
  input wire logic        arr_rd,
  input wire logic        arr_prog,
  input wire logic        arr_erase,
  input wire logic        arr_mass
);
  logic       info_en;
  logic [2:0] arr_sector;
  int         prog_cnt;
  int         erase_cnt;
  int         mass_cnt;
  assign info_en    = page_select[7];
  assign arr_sector = (FLASH_BYTES == 8192) ? arr_addr[12:10] : arr_addr[11:9];
  // ----------------------------------------
  // strobe length counters
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prog_cnt  <= 0;
      erase_cnt <= 0;
      mass_cnt  <= 0;
    end else begin
      prog_cnt  <= arr_prog ? prog_cnt + 1 : 0;
      erase_cnt <= arr_erase ? erase_cnt + 1 : 0;
      mass_cnt  <= arr_mass ? mass_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_read_answer: assert property (clk_en && arr_rd && !busy |=> rd_valid && rd_data == $past(arr_rdata))
    else $error("array read not returned next cycle");
  a_valid_pulse: assert property (rd_valid |=> !rd_valid)
    else $error("read valid longer than one cycle");
  a_info_gate: assert property (rd_valid && !$past(arr_rd) |-> $past(info_en, 2))
    else $error("info read without enable");
  a_strobe_excl: assert property ($onehot0({arr_rd, arr_prog, arr_erase, arr_mass}))
    else $error("array strobes overlap");
  a_busy_cover: assert property (arr_prog || arr_erase || arr_mass |-> busy)
    else $error("strobe active while not busy");
  a_prog_time: assert property ($fell(arr_prog) |-> prog_cnt == PROG_CYC)
    else $error("program strobe length wrong");
  a_erase_time: assert property ($fell(arr_erase) |-> erase_cnt == ERASE_CYC)
    else $error("erase strobe length wrong");
  a_mass_time: assert property ($fell(arr_mass) |-> mass_cnt == MASS_CYC)
    else $error("mass erase strobe length wrong");
  a_prog_lock: assert property ($rose(arr_prog) |-> $past(unlocked, 2) || $past(dbg_prog_req, 2))
    else $error("program started while locked");
  a_prog_sector: assert property ($rose(arr_prog) |-> !sector_protect[arr_sector])
    else $error("program in protected sector");
  a_protect_sticky: assert property (($past(sector_protect) & ~sector_protect) == 8'h00)
    else $error("sector protection cleared");
  a_erase_start: assert property ($rose(arr_erase) |-> !unlocked && arr_addr[8:0] == 9'h000)
    else $error("erase not page aligned or not relocked");
  a_unlock_cause: assert property ($rose(unlocked) |-> $past(reg_wr) && $past(reg_sel))
    else $error("unlock without page rewrite");
endmodule : flash_map_front_sva

bind flash_map_front flash_map_front_sva #(
  .FLASH_BYTES(FLASH_BYTES), .PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC), .MASS_CYC(MASS_CYC)
) i_sva (
  .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .dbg_prog_req(dbg_prog_req), .reg_wr(reg_wr),
  .reg_sel(reg_sel), .arr_rdata(arr_rdata), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
  .unlocked(unlocked), .page_select(page_select), .sector_protect(sector_protect), .arr_addr(arr_addr),
  .arr_rd(arr_rd), .arr_prog(arr_prog), .arr_erase(arr_erase), .arr_mass(arr_mass)
);

// ---- verif/flash_map_front_tb_top.sv ----
// self-checking bench for the flash map front end
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module flash_map_front_tb_top;
  typedef struct {logic ld; logic en; logic [15:0] a; logic [7:0] d;} row_t;
  logic        clk_sys, rstn = 0, clk_en = 1, fetch_req = 0, load_req = 0, store_req = 0;
  logic        reg_wr = 0, reg_sel = 0, dbg_prog_req = 0, dbg_erase_req = 0, dbg_mass_req = 0;
  logic [15:0] fetch_addr = 0, load_addr = 0, store_addr = 0, dbg_addr = 0, arr_addr;
  logic [7:0]  store_data = 0, reg_wdata = 0, dbg_wdata = 0, arr_rdata, rd_data, page_select;
  logic [7:0]  sector_protect, arr_wdata, d;
  logic        rd_valid, busy, unlocked, arr_rd, arr_prog, arr_erase, arr_mass, rs;
  int          bad_count = 0, check_count = 0;
  row_t rows [10] = '{'{0, 0, 16'h0000, 8'h00}, '{0, 0, 16'h1FFF, 8'hE0}, '{1, 0, 16'h0100, 8'h01},
    '{1, 1, 16'hFE40, 8'h46}, '{1, 1, 16'hFE53, 8'h31}, '{1, 1, 16'hFE54, 8'hFF}, '{1, 1, 16'hFE00, 8'hFF},
    '{1, 1, 16'hFFFF, 8'hFF}, '{1, 1, 16'h0200, 8'h02}, '{0, 1, 16'hFE40, 8'h5E}};
  flash_map_front #(.FLASH_BYTES(8192), .PROG_CYC(4), .ERASE_CYC(8), .MASS_CYC(12)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .load_req(load_req), .load_addr(load_addr), .store_req(store_req), .store_addr(store_addr),
    .store_data(store_data), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .dbg_prog_req(dbg_prog_req), .dbg_erase_req(dbg_erase_req), .dbg_mass_req(dbg_mass_req),
    .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .arr_rdata(arr_rdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy), .unlocked(unlocked), .page_select(page_select),
    .sector_protect(sector_protect), .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_wdata(arr_wdata),
    .arr_prog(arr_prog), .arr_erase(arr_erase), .arr_mass(arr_mass));
  flash_array_model i_arr (.clk_sys(clk_sys), .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_wdata(arr_wdata),
    .arr_prog(arr_prog), .arr_erase(arr_erase), .arr_mass(arr_mass), .arr_rdata(arr_rdata));
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic s, input logic [7:0] v);
    reg_wr = 1;
    reg_sel = s;
    reg_wdata = v;
    tick();
  endtask : wr
  task automatic rd(input logic ld, input logic [15:0] a, output logic [7:0] q);
    fetch_req = !ld;
    load_req = ld;
    fetch_addr = a;
    load_addr = a;
    tick();
    fetch_req = 0;
    load_req = 0;
    rs = arr_rd;
    tick();
    `CHK(rd_valid, 1'b1)
    q = rd_data;
  endtask : rd
  task automatic unlock(input logic [7:0] p);
    wr(0, 8'h00);
    wr(1, p);
    wr(0, 8'h73);
    wr(0, 8'h8C);
    wr(1, p);
    reg_wr = 0;
  endtask : unlock
  task automatic store(input logic [15:0] a, input logic [7:0] v);
    store_addr = a;
    store_data = v;
    store_req = 1;
    tick();
    store_req = 0;
  endtask : store
  task automatic wait_idle();
    int n;
    n = 0;
    tick();
    while (busy === 1'b1 && n < 100) begin
      tick();
      n++;
    end
    `CHK(busy, 1'b0)
  endtask : wait_idle
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rstn = 1;
    `CHK({busy, unlocked, page_select, sector_protect, arr_wdata}, {2'b00, 16'h0000, 8'hFF})
    foreach (rows[i]) begin
      if (page_select[7] !== rows[i].en) begin
        wr(1, {rows[i].en, 7'h00});
        reg_wr = 0;
      end
      rd(rows[i].ld, rows[i].a, d);
      `CHK(d, rows[i].d)
      `CHK(rs, !(rows[i].ld && rows[i].en && rows[i].a >= 16'hFE00))
    end
    fetch_req = 1;
    load_req = 1;
    fetch_addr = 16'hFE40;
    load_addr = 16'hFE40;
    tick();
    fetch_req = 0;
    load_req = 0;
    tick();
    `CHK({rd_valid, rd_data}, {1'b1, 8'h5E})
    store(16'hFE40, 8'h00);
    `CHK(busy, 1'b0)
    rd(1, 16'hFE40, d);
    `CHK(d, 8'h46)
    unlock(8'h01);
    `CHK(unlocked, 1'b1)
    store(16'h0210, 8'h0F);
    `CHK(busy, 1'b1)
    wait_idle();
    `CHK(unlocked, 1'b1)
    store(16'h0400, 8'h00);
    `CHK(busy, 1'b0)
    rd(0, 16'h0210, d);
    `CHK(d, 8'h02)
    wr(0, 8'h95);
    reg_wr = 0;
    `CHK({arr_erase, busy, unlocked, arr_addr}, {3'b110, 16'h0200})
    wait_idle();
    rd(0, 16'h0210, d);
    `CHK(d, 8'hFF)
    rd(0, 16'h01FF, d);
    `CHK(d, 8'hFE)
    rd(0, 16'h0400, d);
    `CHK(d, 8'h04)
    wr(0, 8'h00);
    wr(1, 8'h01);
    wr(0, 8'h73);
    wr(1, 8'h01);
    wr(0, 8'h8C);
    wr(1, 8'h01);
    reg_wr = 0;
    `CHK(unlocked, 1'b0)
    wr(0, 8'h00);
    wr(0, 8'h5E);
    wr(1, 8'h02);
    wr(1, 8'h00);
    wr(0, 8'h00);
    reg_wr = 0;
    `CHK(sector_protect, 8'h02)
    unlock(8'h02);
    store(16'h0400, 8'h00);
    `CHK(busy, 1'b0)
    wr(0, 8'h95);
    reg_wr = 0;
    `CHK(arr_erase, 1'b0)
    dbg_mass_req = 1;
    tick();
    dbg_mass_req = 0;
    `CHK(arr_mass, 1'b1)
    wait_idle();
    rd(0, 16'h0400, d);
    `CHK(d, 8'hFF)
    dbg_addr = 16'h0000;
    dbg_wdata = 8'h3C;
    dbg_prog_req = 1;
    tick();
    dbg_prog_req = 0;
    wait_idle();
    rd(0, 16'h0000, d);
    `CHK(d, 8'h3C)
    dbg_addr = 16'h0400;
    dbg_erase_req = 1;
    tick();
    dbg_erase_req = 0;
    `CHK({arr_erase, busy}, 2'b00)
    tick();
    dbg_addr = 16'h0000;
    dbg_erase_req = 1;
    tick();
    dbg_erase_req = 0;
    `CHK({arr_erase, arr_addr}, {1'b1, 16'h0000})
    wait_idle();
    rd(0, 16'h0000, d);
    `CHK(d, 8'hFF)
    rstn = 0;
    tick();
    tick();
    `CHK({sector_protect, page_select, unlocked}, 17'h0_0000)
    rstn = 1;
    clk_en = 0;
    fetch_req = 1;
    fetch_addr = 16'h0400;
    tick();
    tick();
    `CHK({arr_rd, rd_valid}, 2'b00)
    clk_en = 1;
    tick();
    fetch_req = 0;
    `CHK({arr_rd, arr_addr}, {1'b1, 16'h0400})
    tick();
    `CHK({rd_valid, rd_data}, {1'b1, 8'hFF})
    end_sim();
  end
endmodule : flash_map_front_tb_top
